// >>> core/ppc_pkg.sv
// Constants, field layouts and carrier types of the pin-change interrupt block
// ----------------------------------------------------------------------------
// Contract
// (RL1) Rising enable: rising edge sets pin and summary flags
// (RL2) Falling enable: falling edge sets pin and summary flags
// (RL3) Both enables clear: pin flag never set
// (RL4) Flag bit rises only from enabled edge
// (RL5) Software clears flag by writing zero
// (RL6) Hardware set independent of other bit writes
// (RL7) Eight-bit registers, all reset to zero
// (RL8) Master enable off: flags still set, no request; irq still rises from irq_stat wherever irq_mask is set
// (RL9) Summary flag is OR of pin flags
// (RL10) Edge during flag write leaves flag set
// (RL11) Edge wakes device when master enable set
// (RL12) Synchronise pins, compare current and previous samples
// ----------------------------------------------------------------------------
package ppc_pkg;

    // ------------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------------
    localparam int PINS = 8;
    localparam int DEC_W = 8;
    localparam int STAT_W = 2;

    // ------------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------------
    localparam logic [7:0] OFF_RISE_EN = 8'h00;
    localparam logic [7:0] OFF_FALL_EN = 8'h04;
    localparam logic [7:0] OFF_FLAG = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_PIN_LEVEL = 8'h18;

    // ------------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------------
    localparam int CTRL_MASTER_EN_BIT = 0;
    localparam int CTRL_SUMMARY_BIT = 1;
    localparam int STAT_EDGE_BIT = 0;
    localparam int STAT_COLLIDE_BIT = 1;

    // ------------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_STAT = 2'h0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] WARM_CYCLES = 2'h3;

    // ------------------------------------------------------------------------
    // Bus encodings
    // ------------------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        PPC_BUS_IDLE,
        PPC_BUS_WRITE,
        PPC_BUS_RD_WAIT,
        PPC_BUS_RD_DONE
    } ppc_bus_e;

    // Captured address phase
    typedef struct packed {
        logic [7:0] addr;
        logic write;
    } ppc_addr_s;

    // Per-pin edge pulses
    typedef struct packed {
        logic [7:0] rise;
        logic [7:0] fall;
    } ppc_edge_s;

endpackage : ppc_pkg

// >>> core/ppc_pin_edge.sv
// One pin: two-stage synchroniser and edge detector
`timescale 1ns/1ps
module ppc_pin_edge (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin,
    input wire logic edge_ok,
    output logic level,
    output logic rise,
    output logic fall
);
    logic sync_a;
    logic sync_b;
    logic prev;

    // (RL12) sync then compare
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            prev <= 1'b0;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
            prev <= sync_b;
        end
    end

    // Gated until the pipe holds real samples, so no false edge at reset release
    assign level = sync_b;
    assign rise = edge_ok & sync_b & ~prev;
    assign fall = edge_ok & ~sync_b & prev;

endmodule : ppc_pin_edge

// >>> core/ppc_top.sv
// Pin-change interrupt block: edge detect, flags, AHB-Lite register slave
`timescale 1ns/1ps
module ppc_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [7:0] port_pin_n,
    output logic change_irq_req,
    output logic wake_req,
    output logic irq
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [7:0] rising_edge_enable_reg;
    logic [7:0] falling_edge_enable_reg;
    logic [7:0] pin_change_flag_reg;
    logic [7:0] next_flag;
    logic [7:0] set_vec;
    logic [7:0] pin_level;
    logic change_irq_master_enable;
    logic change_irq_summary_flag;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] next_stat;
    logic [1:0] stat_evt;
    logic [1:0] warm;
    logic edge_ok;
    ppc_pkg::ppc_edge_s edges;
    ppc_pkg::ppc_addr_s aph;
    ppc_pkg::ppc_bus_e bus_st;
    ppc_pkg::ppc_bus_e next_bus_st;
    logic take;
    logic wr_now;
    logic rd_now;
    logic wr_flag;
    logic rd_stat;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            warm <= 2'h0;
        end else if (warm != ppc_pkg::WARM_CYCLES) begin
            warm <= warm + 2'h1;
        end
    end

    assign edge_ok = (warm == ppc_pkg::WARM_CYCLES);

    for (genvar i = 0; i < ppc_pkg::PINS; i++) begin : g_pin
        ppc_pin_edge u_edge (
            .hclk(hclk),
            .hresetn(hresetn),
            .pin(port_pin_n[i]),
            .edge_ok(edge_ok),
            .level(pin_level[i]),
            .rise(edges.rise[i]),
            .fall(edges.fall[i])
        );
    end

    // (RL1) (RL2) (RL3) enabled edges only
    assign set_vec = (edges.rise & rising_edge_enable_reg) | (edges.fall & falling_edge_enable_reg);

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------
    assign take = hsel & (htrans == ppc_pkg::HTRANS_NONSEQ) & hready;
    assign wr_now = (bus_st == ppc_pkg::PPC_BUS_WRITE);
    assign rd_now = (bus_st == ppc_pkg::PPC_BUS_RD_WAIT);
    assign wr_flag = wr_now & (aph.addr == ppc_pkg::OFF_FLAG);
    assign rd_stat = rd_now & (aph.addr == ppc_pkg::OFF_IRQ_STAT);

    always_comb begin
        next_bus_st = bus_st;
        case (bus_st)
            ppc_pkg::PPC_BUS_RD_WAIT: begin
                next_bus_st = ppc_pkg::PPC_BUS_RD_DONE;
            end
            ppc_pkg::PPC_BUS_IDLE, ppc_pkg::PPC_BUS_WRITE, ppc_pkg::PPC_BUS_RD_DONE: begin
                if (take) begin
                    next_bus_st = hwrite ? ppc_pkg::PPC_BUS_WRITE : ppc_pkg::PPC_BUS_RD_WAIT;
                end else begin
                    next_bus_st = ppc_pkg::PPC_BUS_IDLE;
                end
            end
            default: begin
                next_bus_st = ppc_pkg::PPC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_st <= ppc_pkg::PPC_BUS_IDLE;
            aph <= '0;
        end else begin
            bus_st <= next_bus_st;
            if (take) begin
                aph.addr <= haddr[ppc_pkg::DEC_W-1:0];
                aph.write <= hwrite;
            end
        end
    end

    // Reads take one wait state so a write just before is already visible
    assign hreadyout = (bus_st != ppc_pkg::PPC_BUS_RD_WAIT);
    assign hresp = ppc_pkg::HRESP_OKAY;

    always_comb begin
        rd_mux = ppc_pkg::RST_WORD;
        case (aph.addr)
            ppc_pkg::OFF_RISE_EN: rd_mux[7:0] = rising_edge_enable_reg;
            ppc_pkg::OFF_FALL_EN: rd_mux[7:0] = falling_edge_enable_reg;
            ppc_pkg::OFF_FLAG: rd_mux[7:0] = pin_change_flag_reg;
            ppc_pkg::OFF_CTRL: begin
                rd_mux[ppc_pkg::CTRL_MASTER_EN_BIT] = change_irq_master_enable;
                rd_mux[ppc_pkg::CTRL_SUMMARY_BIT] = change_irq_summary_flag;
            end
            ppc_pkg::OFF_IRQ_STAT: rd_mux[1:0] = irq_stat;
            ppc_pkg::OFF_IRQ_MASK: rd_mux[1:0] = irq_mask;
            ppc_pkg::OFF_PIN_LEVEL: rd_mux[7:0] = pin_level;
            default: rd_mux = ppc_pkg::RST_WORD;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= ppc_pkg::RST_WORD;
        end else if (rd_now) begin
            hrdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    // (RL7) all clear on any reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rising_edge_enable_reg <= ppc_pkg::RST_BYTE;
            falling_edge_enable_reg <= ppc_pkg::RST_BYTE;
            change_irq_master_enable <= 1'b0;
            irq_mask <= ppc_pkg::RST_STAT;
        end else if (wr_now) begin
            case (aph.addr)
                ppc_pkg::OFF_RISE_EN: rising_edge_enable_reg <= hwdata[7:0];
                ppc_pkg::OFF_FALL_EN: falling_edge_enable_reg <= hwdata[7:0];
                ppc_pkg::OFF_CTRL: change_irq_master_enable <= hwdata[ppc_pkg::CTRL_MASTER_EN_BIT];
                ppc_pkg::OFF_IRQ_MASK: irq_mask <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Change flags
    // ------------------------------------------------------------------------
    // (RL5) (RL4) writes only clear; ones written leave a bit as it was
    // (RL6) (RL10) a hardware set wins over a clear in the same cycle
    always_comb begin
        next_flag = pin_change_flag_reg;
        if (wr_flag) begin
            next_flag = pin_change_flag_reg & hwdata[7:0];
        end
        next_flag = next_flag | set_vec;
    end

    // (RL7) flags clear on any reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_change_flag_reg <= ppc_pkg::RST_BYTE;
        end else begin
            pin_change_flag_reg <= next_flag;
        end
    end

    // (RL9) (RL8) summary follows flags, request gated by enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            change_irq_summary_flag <= 1'b0;
            change_irq_req <= 1'b0;
        end else begin
            change_irq_summary_flag <= |next_flag;
            change_irq_req <= change_irq_master_enable & (|next_flag);
        end
    end

    // (RL11) wake request tracks the gated request; flags already updated
    assign wake_req = change_irq_req;

    // ------------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------------
    assign stat_evt[ppc_pkg::STAT_EDGE_BIT] = |set_vec;
    assign stat_evt[ppc_pkg::STAT_COLLIDE_BIT] = wr_flag & (|(set_vec & ~hwdata[7:0]));

    // Read clears, a new event in the same cycle survives
    always_comb begin
        next_stat = rd_stat ? ppc_pkg::RST_STAT : irq_stat;
        next_stat = next_stat | stat_evt;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= ppc_pkg::RST_STAT;
        end else begin
            irq_stat <= next_stat;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_read_taken;
        take && !hwrite;
    endsequence

    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    chk_rise_sets_flag: assert property ( // RL1
        (edges.rise & rising_edge_enable_reg) != 8'h00
        |=> ((pin_change_flag_reg & $past(edges.rise & rising_edge_enable_reg))
             == $past(edges.rise & rising_edge_enable_reg)) && change_irq_summary_flag)
        else $error("enabled rising edge did not set flag");

    chk_fall_sets_flag: assert property ( // RL2
        (edges.fall & falling_edge_enable_reg) != 8'h00
        |=> ((pin_change_flag_reg & $past(edges.fall & falling_edge_enable_reg))
             == $past(edges.fall & falling_edge_enable_reg)) && change_irq_summary_flag)
        else $error("enabled falling edge did not set flag");

    chk_flag_only_edge: assert property ( // RL4
        ((pin_change_flag_reg & ~$past(pin_change_flag_reg)) & ~$past(set_vec)) == 8'h00)
        else $error("flag bit rose without an enabled edge");

    // Per pin: a bit whose two enables were both clear must not rise
    chk_disabled_pin_quiet: assert property ( // RL3
        ((pin_change_flag_reg & ~$past(pin_change_flag_reg))
         & ~$past(rising_edge_enable_reg | falling_edge_enable_reg)) == 8'h00)
        else $error("flag set on a pin with both enables clear");

    chk_write_clears: assert property ( // RL5
        wr_flag && (set_vec == 8'h00) |=> pin_change_flag_reg == ($past(pin_change_flag_reg) & $past(hwdata[7:0])))
        else $error("flag write did not clear written zeros");

    chk_set_beats_write: assert property ( // RL10
        wr_flag && (set_vec != 8'h00) |=> (pin_change_flag_reg & $past(set_vec)) == $past(set_vec))
        else $error("edge lost during flag write");

    chk_master_gate: assert property ( // RL8
        !change_irq_master_enable ##1 !change_irq_master_enable |-> !change_irq_req)
        else $error("request raised with master enable clear");

    chk_summary_or: assert property ( // RL9
        ##1 change_irq_summary_flag == (pin_change_flag_reg != 8'h00))
        else $error("summary flag differs from OR of flags");

    chk_pin_pipeline: assert property ( // RL12
        edges.rise[0] |-> $past(port_pin_n[0], 2) && !$past(port_pin_n[0], 3))
        else $error("rising pulse without matching pin history");

    chk_read_wait: assert property (
        s_read_taken |=> s_one_wait)
        else $error("read did not take exactly one wait state");

    chk_stat_read_clear: assert property (
        rd_stat && (stat_evt == 2'h0) |=> irq_stat == 2'h0)
        else $error("status read did not clear");

endmodule : ppc_top

// >>> test/ppc_pin_src.sv
// Off-chip source that drives the eight port pins
`timescale 1ns/1ps
module ppc_pin_src (
    input wire logic hclk,
    output logic [7:0] port_pin_n
);
    initial port_pin_n = 8'h00;

    // ------------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------------
    // Edges held whole cycles
    // Shorter pulses could slip between samples, so a level always holds past an edge
    task automatic drive(input logic [7:0] lvl, input int hold);
        @(posedge hclk);
        port_pin_n <= lvl;
        repeat (hold) @(posedge hclk);
    endtask : drive
endmodule : ppc_pin_src

// >>> test/tb.sv
// Self-checking bench for the pin-change interrupt block
`timescale 1ns/1ps
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic [7:0] port_pin_n;
    logic change_irq_req;
    logic wake_req;
    logic irq;
    logic [31:0] rd;
    int n_errors = 0;
    int samples_checked = 0;

    assign hready = hreadyout;
    always #5 hclk = ~hclk;

    ppc_pin_src pins (.hclk(hclk), .port_pin_n(port_pin_n));

    ppc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .port_pin_n(port_pin_n), .change_irq_req(change_irq_req),
        .wake_req(wake_req), .irq(irq));

    // ------------------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------------------
    // Ready is looked at mid-cycle, so the deciding edge never races its update
    task automatic wait_ready();
        do @(negedge hclk); while (hreadyout !== 1'b1);
        @(posedge hclk);
    endtask : wait_ready

    task automatic bus(input logic [7:0] addr, input logic wr, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, addr};
        htrans <= ppc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus

    // ------------------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] addr, input logic [31:0] exp);
        bus(addr, 1'b0, 32'h0000_0000);
        chk(rd, exp);
        chk({31'h0, hresp}, {31'h0, ppc_pkg::HRESP_OKAY});
    endtask : rchk

    // Lets registered outputs land before they are looked at
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask : settle

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(ppc_pkg::OFF_RISE_EN, ppc_pkg::RST_WORD);
        rchk(ppc_pkg::OFF_FALL_EN, ppc_pkg::RST_WORD);
        rchk(ppc_pkg::OFF_FLAG, ppc_pkg::RST_WORD);
        rchk(ppc_pkg::OFF_CTRL, ppc_pkg::RST_WORD);
        rchk(ppc_pkg::OFF_IRQ_MASK, ppc_pkg::RST_WORD);
        bus(8'h1c, 1'b1, 32'h0000_00ff);
        rchk(8'h1c, 32'h0000_0000);
        // Pins 0-3 rise only, 4-5 fall only, 6-7 neither
        bus(ppc_pkg::OFF_RISE_EN, 1'b1, 32'h0000_000f);
        bus(ppc_pkg::OFF_FALL_EN, 1'b1, 32'h0000_0030);
        rchk(ppc_pkg::OFF_RISE_EN, 32'h0000_000f);
        rchk(ppc_pkg::OFF_FALL_EN, 32'h0000_0030);
        pins.drive(8'hff, 5);
        rchk(ppc_pkg::OFF_FLAG, 32'h0000_000f);
        rchk(ppc_pkg::OFF_PIN_LEVEL, 32'h0000_00ff);
        rchk(ppc_pkg::OFF_CTRL, 32'h0000_0002);
        chk({31'h0, change_irq_req}, 32'h0);
        pins.drive(8'h00, 5);
        rchk(ppc_pkg::OFF_FLAG, 32'h0000_003f);
        bus(ppc_pkg::OFF_FLAG, 1'b1, 32'h0000_0030);
        rchk(ppc_pkg::OFF_FLAG, 32'h0000_0030);
        bus(ppc_pkg::OFF_FLAG, 1'b1, 32'h0000_0000);
        rchk(ppc_pkg::OFF_FLAG, 32'h0000_0000);
        rchk(ppc_pkg::OFF_CTRL, 32'h0000_0000);
        // Status and mask
        bus(ppc_pkg::OFF_IRQ_MASK, 1'b1, 32'h0000_0003);
        settle(0);
        chk({31'h0, irq}, 32'h1);
        rchk(ppc_pkg::OFF_IRQ_STAT, 32'h0000_0001);
        settle(1);
        chk({31'h0, irq}, 32'h0);
        // Edge lands on the same edge as a clearing write
        // Pulse reaches the flag logic two edges on, in the write's data phase
        pins.drive(8'h01, 0);
        bus(ppc_pkg::OFF_FLAG, 1'b1, 32'h0000_0000);
        rchk(ppc_pkg::OFF_FLAG, 32'h0000_0001);
        chk({31'h0, irq}, 32'h1);
        rchk(ppc_pkg::OFF_IRQ_STAT, 32'h0000_0003);
        settle(1);
        chk({31'h0, irq}, 32'h0);
        // Masked edge still recorded
        bus(ppc_pkg::OFF_IRQ_MASK, 1'b1, 32'h0000_0000);
        pins.drive(8'h00, 5);
        pins.drive(8'h03, 5);
        rchk(ppc_pkg::OFF_FLAG, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0);
        rchk(ppc_pkg::OFF_IRQ_STAT, 32'h0000_0001);
        // Master enable gates the request
        chk({31'h0, change_irq_req}, 32'h0);
        bus(ppc_pkg::OFF_CTRL, 1'b1, 32'h0000_0001);
        settle(2);
        chk({31'h0, change_irq_req}, 32'h1);
        chk({31'h0, wake_req}, 32'h1);
        rchk(ppc_pkg::OFF_CTRL, 32'h0000_0003);
        bus(ppc_pkg::OFF_FLAG, 1'b1, 32'h0000_0000);
        settle(2);
        chk({31'h0, change_irq_req}, 32'h0);
        rchk(ppc_pkg::OFF_CTRL, 32'h0000_0001);
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        tally_and_finish();
    end
endmodule : tb
